// *** rtl/fid_pkg.sv ***
// Constants shared by the identification readout link ends
//
// Summary of operation
// (RULE1) Quad read uses four two-way lanes
// (RULE2) Quad opcode: one lane, eight clocks, MSB first
// (RULE3) Three dummy address bytes, six clocks, ignored
// (RULE4) Mode byte over two clocks, ignored
// (RULE5) Four dummy clocks precede quad data
// (RULE6) Quad bytes: two clocks each, maker first
// (RULE7) Bits 7..4 then 3..0 on io3..io0
// (RULE8) Quad clocks three, four carry device byte
// (RULE9) Quad bytes repeat while select held
// (RULE10) Extended opcode on io0, no address
// (RULE11) Five bytes on io1 over forty clocks
// (RULE12) One bit per clock, MSB first
// (RULE13) Select release ends transfer, floats io1
// (RULE14) Held select keeps repeating the byte sequence
// (RULE15) Length byte equals one
// (RULE16) Value byte: zero upper nibble, variant code
// (RULE17) Host releases lanes before quad data
package fid_pkg;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_QUAD_ID = 8'h94;
    localparam logic [7:0] OP_EXT_ID = 8'h9F;

    // ------------------------------------------------------------
    // Clock counts of each phase
    // ------------------------------------------------------------
    localparam int OPC_CLKS = 8;
    localparam int QUAD_ADDR_CLKS = 6;
    localparam int QUAD_MODE_CLKS = 2;
    localparam int QUAD_DUMMY_CLKS = 4;
    localparam int QUAD_DATA_START = OPC_CLKS + QUAD_ADDR_CLKS + QUAD_MODE_CLKS
        + QUAD_DUMMY_CLKS;
    localparam int QUAD_HOST_DRIVE_END = OPC_CLKS + QUAD_ADDR_CLKS + QUAD_MODE_CLKS;
    localparam int QUAD_CLKS_PER_BYTE = 2;
    localparam int QUAD_SEQ_CLKS = 4;
    localparam int EXT_CLKS_PER_BYTE = 8;
    localparam int EXT_SEQ_CLKS = 40;

    // ------------------------------------------------------------
    // Identification contents
    // ------------------------------------------------------------
    localparam logic [7:0] EXT_LEN = 8'h01;
    localparam logic [3:0] VARIANT_RESERVED = 4'h8;
    localparam logic [3:0] VARIANT_RST = 4'h0;
    localparam logic [7:0] MODE_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Lane drive codes, enables active low
    // ------------------------------------------------------------
    localparam logic [3:0] OE_NONE = 4'hF;
    localparam logic [3:0] OE_IO0 = 4'hE;
    localparam logic [3:0] OE_IO1 = 4'hD;
    localparam logic [3:0] OE_ALL = 4'h0;

    // Host serial clock half period in system clocks
    localparam int HALF_DEFAULT = 4;

endpackage

// *** rtl/fid_link_if.sv ***
// Serial link between identification host and flash device
`timescale 1ns/10ps
interface fid_link_if;
    logic sck;
    logic cs_n;
    logic [3:0] host_o;
    logic [3:0] host_oe_n;
    logic [3:0] dev_o;
    logic [3:0] dev_oe_n;
    logic [3:0] lane;

    // Resolved lane level, weak pull-up when nobody drives
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign lane[gi] = !dev_oe_n[gi] ? dev_o[gi] :
                              !host_oe_n[gi] ? host_o[gi] : 1'b1;
        end
    endgenerate

    modport host (
        output sck,
        output cs_n,
        output host_o,
        output host_oe_n,
        input lane
    );

    modport dev (
        input sck,
        input cs_n,
        input lane,
        output dev_o,
        output dev_oe_n
    );
endinterface

// *** rtl/fid_dev.sv ***
// Flash device end: answers quad and extended identification reads
`timescale 1ns/10ps
module fid_dev #(
    parameter logic [7:0] MFR_ID = 8'hA5,  // Arbitrary value
    parameter logic [7:0] DEV_ID1 = 8'h3C, // Arbitrary value
    parameter logic [7:0] DEV_ID2 = 8'h5A  // Arbitrary value
) (
    // System clock domain
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Variant code to report, reserved codes refused
    input wire logic [3:0] variant,
    // Frame status in system domain
    output logic frame_busy,
    output logic frame_done,
    output logic last_cmd_quad,
    output logic last_cmd_ext,
    // Link
    fid_link_if.dev link
);

    // ------------------------------------------------------------
    // Stream lookup
    // ------------------------------------------------------------
    function automatic logic [3:0] quad_nibble(input logic [1:0] idx);
        logic [7:0] b;
        b = idx[1] ? DEV_ID1 : MFR_ID; // RULE8
        quad_nibble = idx[0] ? b[3:0] : b[7:4]; // RULE7
    endfunction

    function automatic logic ext_bit(input logic [5:0] idx, input logic [3:0] var_code);
        logic [7:0] b;
        case (idx[5:3])
            3'h0: b = MFR_ID;
            3'h1: b = DEV_ID1;
            3'h2: b = DEV_ID2;
            3'h3: b = fid_pkg::EXT_LEN; // RULE15
            default: b = {4'h0, var_code}; // RULE16
        endcase
        ext_bit = b[3'h7 - idx[2:0]]; // RULE12
    endfunction

    // ------------------------------------------------------------
    // System domain: variant register
    // ------------------------------------------------------------
    logic [3:0] variant_q;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic link_idle;

    // Word frozen while selected, settled before the first serial clock
    // Select must lead the first serial clock by a few clocks
    assign link_idle = cs_s2 && cs_s3;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            variant_q <= fid_pkg::VARIANT_RST;
        end else if (ce && link_idle && variant < fid_pkg::VARIANT_RESERVED) begin // RULE16
            variant_q <= variant;
        end
    end

    // ------------------------------------------------------------
    // Link domain: variant crossing, static level
    // ------------------------------------------------------------
    logic [3:0] var_s1;
    logic [3:0] var_s2;

    always_ff @(posedge link.sck) begin
        var_s1 <= variant_q;
        var_s2 <= var_s1;
    end

    // ------------------------------------------------------------
    // Link domain: opcode capture and clock counting
    // ------------------------------------------------------------
    logic [4:0] clk_cnt;
    logic [7:0] opcode;
    logic [5:0] data_idx;
    logic is_quad;
    logic is_ext;
    logic data_on;

    assign is_quad = opcode == fid_pkg::OP_QUAD_ID;
    assign is_ext = opcode == fid_pkg::OP_EXT_ID;
    // Address, mode and dummy clocks pass with lanes unread
    assign data_on = (is_ext && clk_cnt >= 5'(fid_pkg::OPC_CLKS)) || // RULE10
                     (is_quad && clk_cnt >= 5'(fid_pkg::QUAD_DATA_START)); // RULE3 RULE4 RULE5

    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            clk_cnt <= 5'h00;
        end else if (clk_cnt != 5'(fid_pkg::QUAD_DATA_START)) begin
            clk_cnt <= clk_cnt + 5'h01;
        end
    end

    // Kept after the frame so the system domain can read it
    always_ff @(posedge link.sck) begin
        if (!link.cs_n && clk_cnt < 5'(fid_pkg::OPC_CLKS)) begin
            opcode <= {opcode[6:0], link.lane[0]}; // RULE2 RULE1
        end
    end

    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            data_idx <= 6'h00;
        end else if (data_on) begin
            if (is_quad) begin
                data_idx <= (data_idx == 6'(fid_pkg::QUAD_SEQ_CLKS - 1)) ? 6'h00 // RULE9
                          : data_idx + 6'h01;
            end else begin
                data_idx <= (data_idx == 6'(fid_pkg::EXT_SEQ_CLKS - 1)) ? 6'h00 // RULE14
                          : data_idx + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Link domain: lane drive, changes on falling edge
    // ------------------------------------------------------------
    always_ff @(negedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            link.dev_oe_n <= fid_pkg::OE_NONE; // RULE13
            link.dev_o <= 4'h0;
        end else if (data_on && is_quad) begin
            link.dev_oe_n <= fid_pkg::OE_ALL; // RULE1
            link.dev_o <= quad_nibble(data_idx[1:0]); // RULE6 RULE7
        end else if (data_on) begin
            link.dev_oe_n <= fid_pkg::OE_IO1; // RULE11
            link.dev_o <= {2'h0, ext_bit(data_idx, var_s2), 1'b0}; // RULE12
        end else begin
            link.dev_oe_n <= fid_pkg::OE_NONE;
            link.dev_o <= 4'h0;
        end
    end

    // ------------------------------------------------------------
    // System domain: frame status crossing
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
        end else if (ce) begin
            cs_s1 <= link.cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_busy <= 1'b0;
        end else if (ce) begin
            frame_busy <= !cs_s2;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_done <= 1'b0;
        end else if (ce) begin
            frame_done <= cs_s2 && !cs_s3;
        end else begin
            frame_done <= 1'b0;
        end
    end

    // Opcode is stable once select has been high two clocks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last_cmd_quad <= 1'b0;
            last_cmd_ext <= 1'b0;
        end else if (ce && cs_s2 && !cs_s3) begin
            last_cmd_quad <= is_quad;
            last_cmd_ext <= is_ext;
        end
    end

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (fid_pkg::QUAD_DATA_START >= 32) begin : g_chk_cnt
        $error("clock counter too narrow");
    end
    if (fid_pkg::EXT_SEQ_CLKS > 40) begin : g_chk_ext
        $error("extended sequence exceeds lookup");
    end
    if (fid_pkg::QUAD_CLKS_PER_BYTE != 2 || fid_pkg::QUAD_SEQ_CLKS != 4) begin : g_chk_quad
        $error("quad lookup serves two nibbles of two bytes");
    end
    if (fid_pkg::EXT_CLKS_PER_BYTE != 8 || fid_pkg::EXT_SEQ_CLKS != 40) begin : g_chk_bits
        $error("extended lookup serves five bytes of eight bits");
    end
    if (fid_pkg::VARIANT_RST >= fid_pkg::VARIANT_RESERVED) begin : g_chk_var
        $error("reset variant code is reserved");
    end
    if (fid_pkg::EXT_LEN != 8'h01) begin : g_chk_len // RULE15
        $error("length byte must count one value byte");
    end

endmodule // fid_dev

// *** rtl/fid_host.sv ***
// Host end: issues identification reads and collects the bytes
`timescale 1ns/10ps
module fid_host #(
    parameter int HALF = fid_pkg::HALF_DEFAULT
) (
    // System clock domain
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Request
    input wire logic start,
    input wire logic quad_sel,
    input wire logic [7:0] byte_count,
    output logic busy,
    // Received bytes
    output logic [7:0] rx_data,
    output logic rx_valid,
    // Link
    fid_link_if.host link
);

    typedef enum logic [1:0] {IDLE, SHIFT, FINISH} fid_state_t;

    fid_state_t state;
    logic [7:0] div_cnt;
    logic tick;
    logic [11:0] clk_no;
    logic [7:0] bytes_left;
    logic [7:0] txs;
    logic [7:0] sh;
    logic [2:0] byte_clk;
    logic quad;
    logic [3:0] lane_s1;
    logic [3:0] lane_s2;
    logic in_data;
    logic byte_end;

    assign busy = state != IDLE;
    assign tick = ce && div_cnt == 8'(HALF - 1);
    assign in_data = quad ? clk_no >= 12'(fid_pkg::QUAD_DATA_START)
                          : clk_no >= 12'(fid_pkg::OPC_CLKS);
    assign byte_end = quad ? byte_clk == 3'(fid_pkg::QUAD_CLKS_PER_BYTE - 1)
                           : byte_clk == 3'(fid_pkg::EXT_CLKS_PER_BYTE - 1);

    // ------------------------------------------------------------
    // Lane input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        lane_s1 <= link.lane;
        lane_s2 <= lane_s1;
    end

    // ------------------------------------------------------------
    // Serial clock divider
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || state == IDLE) begin
            div_cnt <= 8'h00;
        end else if (ce) begin
            div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= IDLE;
            link.sck <= 1'b0;
            link.cs_n <= 1'b1;
            link.host_o <= 4'h0;
            link.host_oe_n <= fid_pkg::OE_NONE;
            clk_no <= 12'h000;
            txs <= 8'h00;
            quad <= 1'b0;
        end else if (ce) begin
            case (state)
                IDLE: begin
                    if (start && byte_count != 8'h00) begin
                        quad <= quad_sel;
                        txs <= quad_sel ? fid_pkg::OP_QUAD_ID : fid_pkg::OP_EXT_ID; // RULE2 RULE10
                        link.host_o <= {3'h0, quad_sel ? fid_pkg::OP_QUAD_ID[7]
                                                       : fid_pkg::OP_EXT_ID[7]};
                        link.host_oe_n <= fid_pkg::OE_IO0;
                        link.cs_n <= 1'b0;
                        clk_no <= 12'h000;
                        state <= SHIFT;
                    end
                end
                SHIFT: begin
                    if (tick && !link.sck) begin
                        link.sck <= 1'b1;
                        clk_no <= clk_no + 12'h001;
                    end else if (tick) begin
                        link.sck <= 1'b0;
                        if (bytes_left == 8'h00) begin
                            link.host_oe_n <= fid_pkg::OE_NONE;
                            state <= FINISH;
                        end else if (clk_no < 12'(fid_pkg::OPC_CLKS)) begin
                            txs <= {txs[6:0], 1'b0};
                            link.host_o <= {3'h0, txs[6]};
                        end else if (quad && clk_no < 12'(fid_pkg::QUAD_HOST_DRIVE_END)) begin
                            // Dummy address then mode byte on all lanes
                            link.host_oe_n <= fid_pkg::OE_ALL; // RULE3 RULE4
                            link.host_o <= (clk_no < 12'(fid_pkg::OPC_CLKS
                                + fid_pkg::QUAD_ADDR_CLKS)) ? 4'h0
                                : (clk_no[0] ? fid_pkg::MODE_BYTE[3:0]
                                             : fid_pkg::MODE_BYTE[7:4]);
                        end else begin
                            link.host_oe_n <= fid_pkg::OE_NONE; // RULE17 RULE5
                            link.host_o <= 4'h0;
                        end
                    end
                end
                FINISH: begin
                    if (tick) begin
                        link.cs_n <= 1'b1; // RULE13
                        state <= IDLE;
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data capture on rising serial clock
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sh <= 8'h00;
            byte_clk <= 3'h0;
            bytes_left <= 8'h00;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else if (ce) begin
            rx_valid <= 1'b0;
            if (state == IDLE) begin
                byte_clk <= 3'h0;
                if (start) begin
                    bytes_left <= byte_count;
                end
            end else if (state == SHIFT && tick && !link.sck && in_data
                         && bytes_left != 8'h00) begin
                if (quad) begin
                    sh <= {sh[3:0], lane_s2}; // RULE7
                end else begin
                    sh <= {sh[6:0], lane_s2[1]}; // RULE12
                end
                if (byte_end) begin
                    byte_clk <= 3'h0;
                    bytes_left <= bytes_left - 8'h01;
                    rx_valid <= 1'b1;
                    rx_data <= quad ? {sh[3:0], lane_s2} : {sh[6:0], lane_s2[1]}; // RULE6
                end else begin
                    byte_clk <= byte_clk + 3'h1;
                end
            end
        end else begin
            rx_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (HALF < 3 || HALF > 255) begin : g_chk_half
        $error("HALF must be 3 to 255 for synchronised sampling");
    end

endmodule // fid_host

// *** tb/fid_monitor.sv ***
// Checker of the identification link signals
`timescale 1ns/10ps
module fid_monitor #(
    parameter logic [7:0] MFR_ID = 8'hA5,
    parameter logic [7:0] DEV_ID1 = 8'h3C,
    parameter logic [7:0] DEV_ID2 = 8'h5A
) (
    // System domain
    input wire logic clk,
    input wire logic rst_n,
    // Link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] host_o,
    input wire logic [3:0] host_oe_n,
    input wire logic [3:0] dev_o,
    input wire logic [3:0] dev_oe_n,
    input wire logic [3:0] lane
);
    // ------------------------------------------------------------
    // Frame position and captured opcode
    // ------------------------------------------------------------
    logic [15:0] cnt;
    logic [7:0] op;
    int d_ext;
    int d_quad;
    assign d_ext = (int'(cnt) - 8) % 40;
    assign d_quad = (int'(cnt) - 20) % 4;

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            cnt <= 16'h0000;
        end else if (cnt != 16'hFFFF) begin
            cnt <= cnt + 16'h0001;
        end
    end

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            op <= 8'h00;
        end else if (cnt < 16'h0008) begin
            op <= {op[6:0], lane[0]};
        end
    end

    function automatic logic ext_bit(input int d);
        if (d < 8) return MFR_ID[7 - d];
        if (d < 16) return DEV_ID1[15 - d];
        if (d < 24) return DEV_ID2[23 - d];
        if (d < 32) return fid_pkg::EXT_LEN[31 - d];
        return 1'b0;
    endfunction

    function automatic logic [3:0] quad_nib(input int k);
        case (k)
            0: return MFR_ID[7:4];
            1: return MFR_ID[3:0];
            2: return DEV_ID1[7:4];
            default: return DEV_ID1[3:0];
        endcase
    endfunction

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_OPC_LANE: assert property (@(posedge sck) disable iff (cs_n)
        cnt < 16'h0008 |-> host_oe_n == fid_pkg::OE_IO0)
        else $error("opcode not on io0 alone");
    AST_OPC_VALUE: assert property (@(posedge sck) disable iff (cs_n)
        cnt == 16'h0008 |-> op == fid_pkg::OP_QUAD_ID || op == fid_pkg::OP_EXT_ID)
        else $error("opcode bits wrong");
    AST_DEV_QUIET: assert property (@(posedge sck) disable iff (cs_n)
        cnt < 16'h0008 || (op == fid_pkg::OP_QUAD_ID && cnt < 16'd20)
        |-> dev_oe_n == fid_pkg::OE_NONE)
        else $error("device drives too early");
    AST_HOST_QUAD: assert property (@(posedge sck) disable iff (cs_n)
        op == fid_pkg::OP_QUAD_ID && cnt >= 16'd8 && cnt < 16'd16
        |-> host_oe_n == fid_pkg::OE_ALL)
        else $error("address or mode not on four lanes");
    AST_MODE_BYTE: assert property (@(posedge sck) disable iff (cs_n)
        op == fid_pkg::OP_QUAD_ID && cnt >= 16'h000E && cnt < 16'h0010
        |-> host_o == (cnt[0] ? fid_pkg::MODE_BYTE[3:0] : fid_pkg::MODE_BYTE[7:4]))
        else $error("mode byte nibble wrong");
    AST_HOST_RELEASE: assert property (@(posedge sck) disable iff (cs_n)
        op == fid_pkg::OP_QUAD_ID && cnt >= 16'd16 |-> host_oe_n == fid_pkg::OE_NONE)
        else $error("host still drives lanes");
    AST_QUAD_DRIVE: assert property (@(posedge sck) disable iff (cs_n)
        op == fid_pkg::OP_QUAD_ID && cnt >= 16'd20 |-> dev_oe_n == fid_pkg::OE_ALL)
        else $error("quad data not on all lanes");
    AST_QUAD_NIBBLE: assert property (@(posedge sck) disable iff (cs_n)
        op == fid_pkg::OP_QUAD_ID && cnt >= 16'd20 |-> lane == quad_nib(d_quad))
        else $error("quad nibble wrong");
    AST_EXT_DRIVE: assert property (@(posedge sck) disable iff (cs_n)
        op == fid_pkg::OP_EXT_ID && cnt >= 16'd8 |-> dev_oe_n == fid_pkg::OE_IO1)
        else $error("extended data not on io1");
    AST_EXT_STREAM: assert property (@(posedge sck) disable iff (cs_n)
        op == fid_pkg::OP_EXT_ID && cnt >= 16'd8 && d_ext < 36 |-> lane[1] == ext_bit(d_ext))
        else $error("extended bit wrong");
    AST_CS_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
        cs_n |-> dev_oe_n == fid_pkg::OE_NONE)
        else $error("device drives while deselected");

    COV_QUAD_REPEAT: cover property (@(posedge sck) disable iff (cs_n)
        op == fid_pkg::OP_QUAD_ID && cnt == 16'd28);
    COV_EXT_REPEAT: cover property (@(posedge sck) disable iff (cs_n)
        op == fid_pkg::OP_EXT_ID && cnt == 16'd56);
    COV_RELEASE: cover property (@(posedge clk) disable iff (!rst_n) $rose(cs_n));
endmodule // fid_monitor

// *** tb/flash_id_readout_tb.sv ***
// Testbench joining host and device ends of the identification link
`timescale 1ns/10ps
module flash_id_readout_tb;
    localparam logic [7:0] MFR = 8'hC3;  // Arbitrary value
    localparam logic [7:0] DEV1 = 8'h6E; // Arbitrary value
    localparam logic [7:0] DEV2 = 8'h29; // Arbitrary value

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic start = 1'b0;
    logic quad_sel = 1'b0;
    logic [7:0] byte_count = 8'h00;
    logic [3:0] variant = 4'h0;
    logic frame_busy, frame_done, last_cmd_quad, last_cmd_ext, busy, rx_valid;
    logic [7:0] rx_data;
    int bad_count = 0;
    int total_checks = 0;
    int n_rx = 0;
    int n_done = 0;
    logic [31:0] seed = 32'h00000012;
    logic [3:0] var_m = 4'h0;
    logic [7:0] exp_q[$];

    fid_link_if link();
    fid_dev #(.MFR_ID(MFR), .DEV_ID1(DEV1), .DEV_ID2(DEV2)) fid_dev_inst (.clk(clk),
        .rst_n(rst_n), .ce(ce), .variant(variant), .frame_busy(frame_busy),
        .frame_done(frame_done), .last_cmd_quad(last_cmd_quad),
        .last_cmd_ext(last_cmd_ext), .link(link));
    fid_host #(.HALF(fid_pkg::HALF_DEFAULT)) fid_host_inst (.clk(clk), .rst_n(rst_n),
        .ce(ce), .start(start), .quad_sel(quad_sel), .byte_count(byte_count),
        .busy(busy), .rx_data(rx_data), .rx_valid(rx_valid), .link(link));
    fid_monitor #(.MFR_ID(MFR), .DEV_ID1(DEV1), .DEV_ID2(DEV2)) fid_monitor_inst (
        .clk(clk), .rst_n(rst_n), .sck(link.sck), .cs_n(link.cs_n), .host_o(link.host_o),
        .host_oe_n(link.host_oe_n), .dev_o(link.dev_o), .dev_oe_n(link.dev_oe_n),
        .lane(link.lane));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One read; a second start during the transfer must be ignored
    task automatic run(input logic q, input logic [7:0] n, input logic [3:0] v);
        int w;
        logic [7:0] seq[$];
        variant = v;
        if (v < 4'h8) var_m = v;
        if (q) seq = '{MFR, DEV1};
        else seq = '{MFR, DEV1, DEV2, fid_pkg::EXT_LEN, {4'h0, var_m}};
        exp_q.delete();
        for (int i = 0; i < int'(n); i++) exp_q.push_back(seq[i % seq.size()]);
        n_rx = 0;
        n_done = 0;
        repeat (4) @(posedge clk);
        #2;
        start = 1'b1;
        quad_sel = q;
        byte_count = n;
        @(posedge clk);
        #2;
        start = 1'b0;
        repeat (6) @(posedge clk);
        #2;
        ce = !seed[12];
        repeat (3) @(posedge clk);
        #2;
        ce = 1'b1;
        repeat (3) @(posedge clk);
        #2;
        check_bit(frame_busy, 1'b1);
        start = 1'b1;
        quad_sel = !q;
        @(posedge clk);
        #2;
        start = 1'b0;
        w = 0;
        while (busy !== 1'b0 && w < 20000) begin
            @(posedge clk);
            #2;
            w++;
        end
        if (w >= 20000) bad_count++;
        repeat (8) @(posedge clk);
        #2;
        check_byte(8'(n_rx), n);
        check_bit(last_cmd_quad, q);
        check_bit(last_cmd_ext, !q);
        check_bit(frame_busy, 1'b0);
        check_byte(8'(n_done), 8'h01);
    endtask

    // ------------------------------------------------------------
    // Clock, collector, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end

    always begin
        @(posedge clk);
        #1;
        if (frame_done === 1'b1) n_done++;
        if (rx_valid === 1'b1) begin
            n_rx++;
            if (exp_q.size() != 0) check_byte(rx_data, exp_q.pop_front());
        end
    end

    initial begin
        #1500000;
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge clk);
        #2;
        rst_n = 1'b1;
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            run(i < 16 ? ((i % 3) == 2) : seed[3], 8'(seed[7:4]) + 8'h01,
                i < 16 ? 4'(i) : seed[11:8]);
        end
        end_sim();
    end
endmodule // flash_id_readout_tb
